// ---- rtl/menu_ctl_map.vh ----
`ifndef MENU_CTL_MAP_VH
`define MENU_CTL_MAP_VH
// Register offsets, plain port bus
`define ADDR_FUNC_SEL 4'h0
`define ADDR_CUR_LIVE 4'h1
`define ADDR_ANG_LIVE 4'h2
`define ADDR_CAL_IN_LO 4'h3
`define ADDR_CAL_IN_HI 4'h4
`define ADDR_CAL_ANG_LO 4'h5
`define ADDR_CAL_ANG_HI 4'h6
`define ADDR_FB_TRIM_LO 4'h7
`define ADDR_FB_TRIM_HI 4'h8
`define ADDR_SETTINGS 4'h9
`define ADDR_STATION 4'hA
`define ADDR_STATUS 4'hB
// Menu functions
`define FN_IDLE 4'h0
`define FN_CAL_IN_LO 4'h1
`define FN_CAL_IN_HI 4'h2
`define FN_CAL_ANG_LO 4'h3
`define FN_CAL_ANG_HI 4'h4
`define FN_RESTORE_SA 4'h5
`define FN_RESTORE_DA 4'h6
`define FN_LANGUAGE 4'h7
`define FN_ROTATION 4'h8
`define FN_FB_LO 4'h9
`define FN_FB_HI 4'hA
`define FN_ADDR_NIB 4'hB
`define FN_ADDR_DIRECT 4'hC
// Factory values
`define DEF_STATION 7'h7E
`define DEF_CAL_IN_LO 16'h0FA0
`define DEF_CAL_IN_HI 16'h4E20
`define DEF_CAL_ANG_LO 16'h2000
`define DEF_CAL_ANG_HI 16'hE000
`define DEF_FB_LO 16'h0FA0
`define DEF_FB_HI 16'h4E20
`define DEF_LANG 2'h0
// Timing
`define DEBOUNCE_MS 10
`define BLINK_MS 250
`define REPEAT_MS 200
`define FAST_AFTER_REPEATS 10
`define FAST_STEP 7'h0A
`endif

// ---- rtl/key_debounce.v ----
`timescale 1ns/10ps
module key_debounce #(
    parameter CNT_MAX = 200000
)(
    // Clock and reset
    input wire i_ref_clk,
    input wire i_rst_n,
    // Key
    input wire i_key,
    output reg o_level,
    output reg o_press
);
    reg [17:0] cnt_q;
    reg raw_q;

    // Level only accepted after a full quiet interval, so contact chatter gives one press
    always @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            cnt_q <= 18'h0_0000;
            raw_q <= 1'b0;
            o_level <= 1'b0;
            o_press <= 1'b0;
        end
        else
        begin
            raw_q <= i_key;
            o_press <= 1'b0;
            if (raw_q == o_level)
                cnt_q <= 18'h0_0000;
            else if (cnt_q == CNT_MAX[17:0] - 18'h0_0001)
            begin
                cnt_q <= 18'h0_0000;
                o_level <= raw_q;
                o_press <= raw_q; // RULE_23
            end
            else
                cnt_q <= cnt_q + 18'h0_0001;
        end
    end
endmodule

// ---- rtl/workbench_menu.v ----
// Behaviour
// [RULE_01] Upper current cal: LEDs 1+2, confirm stores
// [RULE_02] Lower current cal stores 4 mA reference
// [RULE_03] Lower angle cal: LED 3, stores -45
// [RULE_04] Upper angle cal: LEDs 1+3, stores +45
// [RULE_05] Single-acting restore: LED 4, reload factory
// [RULE_06] Double-acting restore: LEDs 1+4, reload factory
// [RULE_07] Restore resets all calibrations to factory
// [RULE_08] Choose among three stored menu languages
// [RULE_09] English at factory, change any time
// [RULE_10] Display rotation: upright or half turn
// [RULE_11] Feedback trim: plus/minus adjust, confirm stores
// [RULE_12] First power-up presents language and rotation
// [RULE_13] Station address 7-bit, viewable and changeable
// [RULE_14] Address bits weighted 1 to 64
// [RULE_15] Nibble shown on LEDs, eighth bit zero
// [RULE_16] Lower nibble: M short, LED 1 long
// [RULE_17] Upper nibble: M short, LED 4 long
// [RULE_18] Plus/minus steps address by one
// [RULE_19] Edited address active only on confirm
// [RULE_20] Factory station address is 126
// [RULE_21] Text display gets decimal and hex address
// [RULE_22] Direct entry autorepeats, larger steps later
// [RULE_23] Each debounced press is one event
// [RULE_24] Captured settings go to non-volatile storage
//
// Implementation choices: the placing of the registers and the plain strobed port.
`timescale 1ns/10ps
`include "menu_ctl_map.vh"
module workbench_menu #(
    parameter CLK_HZ = 20000000,
    parameter DEBOUNCE_CYC = `DEBOUNCE_MS * (CLK_HZ / 1000),
    parameter BLINK_CYC = `BLINK_MS * (CLK_HZ / 1000),
    parameter REPEAT_CYC = `REPEAT_MS * (CLK_HZ / 1000)
)(
    // Clock and reset
    input wire i_ref_clk,
    input wire i_rst_n,
    // Keys
    input wire i_key_plus,
    input wire i_key_minus,
    input wire i_key_confirm,
    // Measurements
    input wire [15:0] i_loop_current,
    input wire [15:0] i_angle_raw,
    // Non-volatile store state
    input wire i_nv_first_boot,
    input wire i_nv_busy,
    // Register port
    input wire [3:0] i_addr,
    input wire [15:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    output reg [15:0] o_rdata,
    // Indicators
    output reg [3:0] o_led,
    output reg o_menu_led,
    output reg [1:0] o_language,
    output reg o_display_rotation,
    output reg o_double_acting,
    output reg [15:0] o_fb_drive,
    // Station address for text display
    output reg [6:0] o_station_addr,
    output reg [7:0] o_addr_hex,
    output reg [11:0] o_addr_bcd,
    // Non-volatile save request
    output reg o_nv_save
);
    // ----------------------------------------
    // Keys
    // ----------------------------------------
    wire [2:0] key_raw;
    wire [2:0] key_lvl;
    wire [2:0] key_evt;
    assign key_raw = {i_key_confirm, i_key_minus, i_key_plus};
    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1)
        begin : g_key
            key_debounce #(.CNT_MAX(DEBOUNCE_CYC)) u_deb (
                .i_ref_clk(i_ref_clk),
                .i_rst_n(i_rst_n),
                .i_key(key_raw[g]),
                .o_level(key_lvl[g]),
                .o_press(key_evt[g])
            );
        end
    endgenerate
    wire plus_p = key_evt[0];
    wire minus_p = key_evt[1];
    wire conf_p = key_evt[2];

    // ----------------------------------------
    // State
    // ----------------------------------------
    localparam ST_BOOT = 3'b001;
    localparam ST_SETUP = 3'b010;
    localparam ST_RUN = 3'b100;

    reg [2:0] st_q;
    reg [3:0] func_q;
    reg [15:0] cal_in_lo_q, cal_in_hi_q, cal_ang_lo_q, cal_ang_hi_q, fb_lo_q, fb_hi_q;
    reg [1:0] lang_sel_q;
    reg rot_sel_q;
    reg [6:0] edit_q;
    reg nib_hi_q;
    reg [24:0] blink_cnt_q;
    reg [1:0] phase_q;
    reg [23:0] rep_cnt_q;
    reg [3:0] rep_num_q;
    reg setup_step_q;
    reg save_pend_q;

    // Autorepeat tick while a step key is held in direct entry
    wire held = key_lvl[0] ^ key_lvl[1];
    wire rep_tick = held && (rep_cnt_q == REPEAT_CYC[23:0] - 24'h00_0001);
    wire [6:0] step = (rep_num_q == `FAST_AFTER_REPEATS) ? `FAST_STEP : 7'h01; // RULE_22
    wire is_fb = (func_q == `FN_FB_LO) || (func_q == `FN_FB_HI);
    wire [6:0] rem100 = (edit_q >= 7'd100) ? edit_q - 7'd100 : edit_q;
    wire [6:0] tens7 = rem100 / 7'd10;
    wire [6:0] ones7 = rem100 - 7'd10 * tens7;

    // ----------------------------------------
    // Blink phase: short is one quarter, long one half
    // ----------------------------------------
    always @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            blink_cnt_q <= 25'h000_0000;
            phase_q <= 2'h0;
        end
        else if (blink_cnt_q == BLINK_CYC[24:0] - 25'h000_0001)
        begin
            blink_cnt_q <= 25'h000_0000;
            phase_q <= phase_q + 2'h1;
        end
        else
            blink_cnt_q <= blink_cnt_q + 25'h000_0001;
    end

    always @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            rep_cnt_q <= 24'h00_0000;
            rep_num_q <= 4'h0;
        end
        else if (!held || func_q != `FN_ADDR_DIRECT)
        begin
            rep_cnt_q <= 24'h00_0000;
            rep_num_q <= 4'h0;
        end
        else if (rep_tick)
        begin
            rep_cnt_q <= 24'h00_0000;
            if (rep_num_q != `FAST_AFTER_REPEATS)
                rep_num_q <= rep_num_q + 4'h1;
        end
        else
            rep_cnt_q <= rep_cnt_q + 24'h00_0001;
    end

    // ----------------------------------------
    // Menu engine
    // ----------------------------------------
    always @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            st_q <= ST_BOOT;
            func_q <= `FN_IDLE;
            cal_in_lo_q <= `DEF_CAL_IN_LO;
            cal_in_hi_q <= `DEF_CAL_IN_HI;
            cal_ang_lo_q <= `DEF_CAL_ANG_LO;
            cal_ang_hi_q <= `DEF_CAL_ANG_HI;
            fb_lo_q <= `DEF_FB_LO;
            fb_hi_q <= `DEF_FB_HI;
            lang_sel_q <= `DEF_LANG; // RULE_09
            rot_sel_q <= 1'b0;
            o_double_acting <= 1'b0;
            o_station_addr <= `DEF_STATION; // RULE_20
            edit_q <= `DEF_STATION;
            nib_hi_q <= 1'b0;
            setup_step_q <= 1'b0;
            save_pend_q <= 1'b0;
        end
        else
        begin
            if (save_pend_q && !i_nv_busy)
                save_pend_q <= 1'b0;
            case (st_q)
                ST_BOOT:
                begin
                    // Strap read after reset release, not under reset
                    if (i_nv_first_boot)
                    begin
                        st_q <= ST_SETUP; // RULE_12
                        func_q <= `FN_LANGUAGE;
                    end
                    else
                        st_q <= ST_RUN;
                end
                ST_SETUP:
                begin
                    if (plus_p && !setup_step_q)
                        lang_sel_q <= (lang_sel_q == 2'h2) ? 2'h0 : lang_sel_q + 2'h1;
                    else if (minus_p && !setup_step_q)
                        lang_sel_q <= (lang_sel_q == 2'h0) ? 2'h2 : lang_sel_q - 2'h1;
                    else if (plus_p || minus_p)
                        rot_sel_q <= ~rot_sel_q;
                    if (conf_p)
                    begin
                        setup_step_q <= 1'b1;
                        func_q <= `FN_ROTATION;
                        if (setup_step_q)
                        begin
                            st_q <= ST_RUN; // RULE_12
                            func_q <= `FN_IDLE;
                            save_pend_q <= 1'b1;
                        end
                    end
                end
                ST_RUN:
                begin
                    if (i_wr && i_addr == `ADDR_FUNC_SEL)
                    begin
                        func_q <= i_wdata[3:0];
                        edit_q <= o_station_addr;
                        nib_hi_q <= 1'b0;
                    end
                    if (i_wr && i_addr == `ADDR_SETTINGS)
                    begin
                        lang_sel_q <= (i_wdata[1:0] == 2'h3) ? lang_sel_q : i_wdata[1:0]; // RULE_08
                        rot_sel_q <= i_wdata[2]; // RULE_10
                    end
                    case (func_q)
                        `FN_LANGUAGE:
                            if (plus_p)
                                lang_sel_q <= (lang_sel_q == 2'h2) ? 2'h0 : lang_sel_q + 2'h1; // RULE_09
                            else if (minus_p)
                                lang_sel_q <= (lang_sel_q == 2'h0) ? 2'h2 : lang_sel_q - 2'h1;
                        `FN_ROTATION:
                            if (plus_p || minus_p)
                                rot_sel_q <= ~rot_sel_q; // RULE_10
                        `FN_FB_LO:
                            if (plus_p)
                                fb_lo_q <= fb_lo_q + 16'h0001; // RULE_11
                            else if (minus_p)
                                fb_lo_q <= fb_lo_q - 16'h0001;
                        `FN_FB_HI:
                            if (plus_p)
                                fb_hi_q <= fb_hi_q + 16'h0001; // RULE_11
                            else if (minus_p)
                                fb_hi_q <= fb_hi_q - 16'h0001;
                        `FN_ADDR_NIB:
                            if (plus_p)
                                edit_q <= edit_q + 7'h01; // RULE_18
                            else if (minus_p)
                                edit_q <= edit_q - 7'h01;
                        `FN_ADDR_DIRECT:
                            if (plus_p || (rep_tick && key_lvl[0]))
                                edit_q <= edit_q + step; // RULE_22
                            else if (minus_p || (rep_tick && key_lvl[1]))
                                edit_q <= edit_q - step;
                        default:
                            ;
                    endcase
                    // Nibble toggle via register keeps plus/minus free for stepping
                    if (i_wr && i_addr == `ADDR_STATION && func_q == `FN_ADDR_NIB)
                        nib_hi_q <= i_wdata[8]; // RULE_17
                    if (conf_p)
                    begin
                        save_pend_q <= 1'b1; // RULE_24
                        case (func_q)
                            `FN_CAL_IN_LO: cal_in_lo_q <= i_loop_current; // RULE_02
                            `FN_CAL_IN_HI: cal_in_hi_q <= i_loop_current; // RULE_01
                            `FN_CAL_ANG_LO: cal_ang_lo_q <= i_angle_raw; // RULE_03
                            `FN_CAL_ANG_HI: cal_ang_hi_q <= i_angle_raw; // RULE_04
                            `FN_RESTORE_SA, `FN_RESTORE_DA:
                            begin
                                cal_in_lo_q <= `DEF_CAL_IN_LO; // RULE_07
                                cal_in_hi_q <= `DEF_CAL_IN_HI;
                                cal_ang_lo_q <= `DEF_CAL_ANG_LO;
                                cal_ang_hi_q <= `DEF_CAL_ANG_HI;
                                fb_lo_q <= `DEF_FB_LO;
                                fb_hi_q <= `DEF_FB_HI;
                                o_double_acting <= (func_q == `FN_RESTORE_DA); // RULE_05 RULE_06
                            end
                            `FN_ADDR_NIB, `FN_ADDR_DIRECT:
                                o_station_addr <= edit_q; // RULE_19
                            default:
                                ;
                        endcase
                    end
                end
                default:
                    st_q <= ST_BOOT;
            endcase
        end
    end

    // ----------------------------------------
    // Indicator patterns
    // ----------------------------------------
    reg [3:0] led_d;
    reg menu_d;
    always @*
    begin
        led_d = 4'h0;
        menu_d = 1'b0;
        case (func_q)
            `FN_CAL_IN_LO: led_d = 4'b0010;
            `FN_CAL_IN_HI: led_d = 4'b0011; // RULE_01
            `FN_CAL_ANG_LO: led_d = 4'b0100; // RULE_03
            `FN_CAL_ANG_HI: led_d = 4'b0101; // RULE_04
            `FN_RESTORE_SA: led_d = 4'b1000; // RULE_05
            `FN_RESTORE_DA: led_d = 4'b1001; // RULE_06
            `FN_ADDR_NIB:
            begin
                // Marker phase alternates with the displayed bits
                if (phase_q[1] == 1'b0)
                begin
                    menu_d = (phase_q == 2'h0); // RULE_16 RULE_17
                    led_d = nib_hi_q ? 4'b1000 : 4'b0001;
                end
                else
                    led_d = nib_hi_q ? {1'b0, edit_q[6:4]} : edit_q[3:0]; // RULE_14 RULE_15
            end
            default:
                ;
        endcase
    end

    // ----------------------------------------
    // Output and read registers
    // ----------------------------------------
    always @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_led <= 4'h0;
            o_menu_led <= 1'b0;
            o_language <= `DEF_LANG;
            o_display_rotation <= 1'b0;
            o_fb_drive <= 16'h0000;
            o_addr_hex <= 8'h00;
            o_addr_bcd <= 12'h000;
            o_nv_save <= 1'b0;
            o_rdata <= 16'h0000;
        end
        else
        begin
            o_led <= led_d;
            o_menu_led <= menu_d;
            o_language <= lang_sel_q;
            o_display_rotation <= rot_sel_q;
            o_fb_drive <= (func_q == `FN_FB_HI) ? fb_hi_q : (is_fb ? fb_lo_q : 16'h0000); // RULE_11
            o_addr_hex <= {1'b0, edit_q}; // RULE_21
            o_addr_bcd <= {3'b000, edit_q >= 7'd100, tens7[3:0], ones7[3:0]}; // RULE_21
            o_nv_save <= save_pend_q && !i_nv_busy; // RULE_24
            o_rdata <= 16'h0000;
            if (i_rd)
            begin
                case (i_addr)
                    `ADDR_FUNC_SEL: o_rdata <= {12'h000, func_q};
                    `ADDR_CUR_LIVE: o_rdata <= i_loop_current;
                    `ADDR_ANG_LIVE: o_rdata <= i_angle_raw;
                    `ADDR_CAL_IN_LO: o_rdata <= cal_in_lo_q;
                    `ADDR_CAL_IN_HI: o_rdata <= cal_in_hi_q;
                    `ADDR_CAL_ANG_LO: o_rdata <= cal_ang_lo_q;
                    `ADDR_CAL_ANG_HI: o_rdata <= cal_ang_hi_q;
                    `ADDR_FB_TRIM_LO: o_rdata <= fb_lo_q;
                    `ADDR_FB_TRIM_HI: o_rdata <= fb_hi_q;
                    `ADDR_SETTINGS: o_rdata <= {13'h0000, rot_sel_q, lang_sel_q};
                    `ADDR_STATION: o_rdata <= {7'h00, nib_hi_q, 1'b0, o_station_addr}; // RULE_13
                    `ADDR_STATUS: o_rdata <= {9'h000, edit_q};
                    default: o_rdata <= 16'h0000;
                endcase
            end
        end
    end
endmodule

// ---- sim/menu_checker_sva.sv ----
`timescale 1ns/10ps
`include "menu_ctl_map.vh"
module menu_checker (
    // Clock and reset
    input wire i_ref_clk,
    input wire i_rst_n,
    // Keys and register port
    input wire i_key_plus,
    input wire i_key_minus,
    input wire i_key_confirm,
    input wire [3:0] i_addr,
    input wire i_wr,
    input wire i_rd,
    // Outputs watched
    input wire [15:0] o_rdata,
    input wire [1:0] o_language,
    input wire o_display_rotation,
    input wire [6:0] o_station_addr,
    input wire [7:0] o_addr_hex,
    input wire [11:0] o_addr_bcd,
    input wire o_nv_save
);
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);
    function automatic logic [11:0] to_bcd(input logic [6:0] v);
        to_bcd = {4'(v / 100), 4'((v / 10) % 10), 4'(v % 10)};
    endfunction
    sequence s_rd_station;
        i_rd && i_addr == `ADDR_STATION;
    endsequence
    sequence s_rd_settings;
        i_rd && i_addr == `ADDR_SETTINGS;
    endsequence
    a_rdata_idle: assert property (!i_rd |=> o_rdata == 16'h0000)
        else $error("read data not zero outside a read");
    a_rdata_unmapped: assert property (i_rd && i_addr > `ADDR_STATUS |=> o_rdata == 16'h0000)
        else $error("unmapped read not zero");
    a_read_station: assert property (s_rd_station |=> o_rdata[6:0] == $past(o_station_addr))
        else $error("station read differs from active address");
    a_read_settings: assert property (s_rd_settings |=> o_rdata[2:0] == {$past(o_display_rotation), $past(o_language)})
        else $error("settings read differs from outputs");
    a_lang_legal: assert property (o_language != 2'h3)
        else $error("language code out of range");
    a_hex_top_zero: assert property (o_addr_hex[7] == 1'b0)
        else $error("eighth address bit not zero");
    a_bcd_match: assert property ($stable(o_addr_hex) [*3] |-> o_addr_bcd == to_bcd(o_addr_hex[6:0]))
        else $error("decimal address does not match hex");
    a_station_on_confirm: assert property ($changed(o_station_addr) |-> $past(i_key_confirm) || $past(i_wr))
        else $error("active address changed without confirm");
    a_save_pulse: assert property (o_nv_save |=> !o_nv_save)
        else $error("save request longer than one cycle");
    a_lang_cause: assert property ($changed(o_language) |->
        $past(i_wr, 2) || $past(i_key_plus) || $past(i_key_minus) || $past(i_key_confirm))
        else $error("language changed without a request");
endmodule
bind workbench_menu menu_checker i_menu_checker (.i_ref_clk, .i_rst_n, .i_key_plus, .i_key_minus,
    .i_key_confirm, .i_addr, .i_wr, .i_rd, .o_rdata, .o_language, .o_display_rotation, .o_station_addr,
    .o_addr_hex, .o_addr_bcd, .o_nv_save);

// ---- sim/key_operator.sv ----
`timescale 1ns/10ps
module key_operator (
    // Clock and reset
    input wire i_ref_clk,
    input wire i_rst_n,
    // Press request: 0 plus, 1 minus, 2 confirm
    input wire i_go,
    input wire [1:0] i_sel,
    input wire [7:0] i_hold,
    // Keys, high while pressed
    output reg o_key_plus,
    output reg o_key_minus,
    output reg o_key_confirm,
    output reg o_busy
);
    // ----------------------------------------
    // Operator finger
    // ----------------------------------------
    reg [8:0] cnt_q;
    reg [1:0] sel_q;
    reg [7:0] hold_q;
    // Contacts chatter for the first cycles, so a sloppy debounce double-counts
    wire down = o_busy && (cnt_q < {1'b0, hold_q}) && (cnt_q > 9'd2 || cnt_q[0]);
    always @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_busy <= 1'b0;
            cnt_q <= 9'h000;
            sel_q <= 2'h0;
            hold_q <= 8'h00;
        end
        else if (i_go && !o_busy)
        begin
            o_busy <= 1'b1;
            cnt_q <= 9'h000;
            sel_q <= i_sel;
            hold_q <= i_hold;
        end
        else if (o_busy)
        begin
            cnt_q <= cnt_q + 9'd1;
            // Released long enough for the debounce to see the key up
            if (cnt_q == {1'b0, hold_q} + 9'd24)
                o_busy <= 1'b0;
        end
    end
    always @*
    begin
        o_key_plus = down && sel_q == 2'h0;
        o_key_minus = down && sel_q == 2'h1;
        o_key_confirm = down && sel_q == 2'h2;
    end
endmodule

// ---- sim/workbench_menu_tb.sv ----
`timescale 1ns/10ps
`include "menu_ctl_map.vh"
module workbench_menu_tb;
    reg i_ref_clk, i_rst_n, i_nv_first_boot, i_nv_busy, i_wr, i_rd, go;
    reg [1:0] sel;
    reg [7:0] hold;
    reg [3:0] i_addr;
    reg [15:0] i_wdata, i_loop_current, i_angle_raw, rdv;
    wire kp, km, kc, busy, o_menu_led, o_display_rotation, o_double_acting, o_nv_save;
    wire [15:0] o_rdata, o_fb_drive;
    wire [3:0] o_led;
    wire [1:0] o_language;
    wire [6:0] o_station_addr;
    wire [7:0] o_addr_hex;
    wire [11:0] o_addr_bcd;
    integer n_errors, total_checks, k;
    typedef struct packed {logic [3:0] fn; logic [3:0] led; logic [3:0] ra; logic [15:0] cur; logic [15:0] ex;} row_t;
    row_t rows [0:6];
    // ----------------------------------------
    // Design and operator
    // ----------------------------------------
    workbench_menu #(.DEBOUNCE_CYC(4), .BLINK_CYC(4), .REPEAT_CYC(8)) i_workbench_menu (.i_ref_clk, .i_rst_n,
        .i_key_plus(kp), .i_key_minus(km), .i_key_confirm(kc), .i_loop_current, .i_angle_raw, .i_nv_first_boot,
        .i_nv_busy, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .o_led, .o_menu_led, .o_language,
        .o_display_rotation, .o_double_acting, .o_fb_drive, .o_station_addr, .o_addr_hex, .o_addr_bcd, .o_nv_save);
    key_operator i_key_operator (.i_ref_clk, .i_rst_n, .i_go(go), .i_sel(sel), .i_hold(hold),
        .o_key_plus(kp), .o_key_minus(km), .o_key_confirm(kc), .o_busy(busy));
    initial
    begin
        i_ref_clk = 1'b0;
        forever #25 i_ref_clk = ~i_ref_clk;
    end
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task check(input string what, input [15:0] seen, input [15:0] ex);
        total_checks++;
        if (seen !== ex)
        begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, ex, seen);
        end
    endtask
    task wr(input [3:0] a, input [15:0] d);
        @(posedge i_ref_clk) {i_wr, i_addr, i_wdata} <= {1'b1, a, d};
        @(posedge i_ref_clk) i_wr <= 1'b0;
    endtask
    task rd(input [3:0] a);
        @(posedge i_ref_clk) {i_rd, i_addr} <= {1'b1, a};
        @(posedge i_ref_clk) i_rd <= 1'b0;
        @(negedge i_ref_clk) rdv = o_rdata;
    endtask
    task press(input [1:0] s, input [7:0] h);
        @(posedge i_ref_clk) {go, sel, hold} <= {1'b1, s, h};
        @(posedge i_ref_clk) go <= 1'b0;
        @(posedge i_ref_clk);
        while (busy === 1'b1) @(posedge i_ref_clk);
    endtask
    // Blinking display: both the nibble and the marker must appear within two full blink cycles
    task scan(input [3:0] bits, input [3:0] mark);
        reg sb, sm;
        sb = 1'b0;
        sm = 1'b0;
        repeat (32)
        begin
            @(negedge i_ref_clk);
            sb = sb | (o_led === bits);
            sm = sm | (o_led === mark && o_menu_led === 1'b1);
        end
        check("nibble", {15'h0000, sb}, 16'h0001);
        check("marker", {15'h0000, sm}, 16'h0001);
    endtask
    task do_reset;
        @(posedge i_ref_clk) i_rst_n <= 1'b0;
        repeat (6) @(posedge i_ref_clk);
        i_rst_n <= 1'b1;
        repeat (2) @(posedge i_ref_clk);
    endtask
    task finish_test;
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial
    begin
        {i_rst_n, i_nv_first_boot, i_nv_busy, i_wr, i_rd, go, sel, hold, i_addr} = 0;
        {i_wdata, i_loop_current, i_angle_raw, n_errors, total_checks} = 0;
        rows[0] = {`FN_CAL_IN_LO, 4'h2, `ADDR_CAL_IN_LO, 16'h1111, 16'h1111};
        rows[1] = {`FN_CAL_IN_HI, 4'h3, `ADDR_CAL_IN_HI, 16'h2222, 16'h2222};
        rows[2] = {`FN_CAL_ANG_LO, 4'h4, `ADDR_CAL_ANG_LO, 16'h3333, 16'h3333};
        rows[3] = {`FN_CAL_ANG_HI, 4'h5, `ADDR_CAL_ANG_HI, 16'h4444, 16'h4444};
        rows[4] = {`FN_RESTORE_SA, 4'h8, `ADDR_CAL_ANG_HI, 16'h5555, `DEF_CAL_ANG_HI};
        rows[5] = {`FN_CAL_IN_LO, 4'h2, `ADDR_CAL_IN_LO, 16'h6666, 16'h6666};
        rows[6] = {`FN_RESTORE_DA, 4'h9, `ADDR_CAL_IN_LO, 16'h7777, `DEF_CAL_IN_LO};
        do_reset;
        rd(`ADDR_STATION);
        check("station reg", rdv, 16'h007E);
        check("station out", {9'h000, o_station_addr}, 16'h007E);
        rd(`ADDR_SETTINGS);
        check("settings", rdv, 16'h0000);
        rd(4'hF);
        check("unmapped", rdv, 16'h0000);
        $display("test reset done");
        for (k = 0; k < 7; k++)
        begin
            @(posedge i_ref_clk) {i_loop_current, i_angle_raw} <= {rows[k].cur, rows[k].cur};
            wr(`ADDR_FUNC_SEL, {12'h000, rows[k].fn});
            repeat (2) @(posedge i_ref_clk);
            @(negedge i_ref_clk);
            check("leds", {12'h000, o_led}, {12'h000, rows[k].led});
            press(2'h2, 8'd20);
            rd(rows[k].ra);
            check("capture", rdv, rows[k].ex);
        end
        check("double", {15'h0000, o_double_acting}, 16'h0001);
        $display("test calibration done");
        wr(`ADDR_SETTINGS, 16'h0001);
        rd(`ADDR_SETTINGS);
        check("settings", rdv, 16'h0001);
        wr(`ADDR_SETTINGS, 16'h0006);
        wr(`ADDR_SETTINGS, 16'h0007);
        rd(`ADDR_SETTINGS);
        check("settings", rdv, 16'h0006);
        check("language", {14'h0000, o_language}, 16'h0002);
        $display("test settings done");
        wr(`ADDR_FUNC_SEL, {12'h000, `FN_ADDR_NIB});
        press(2'h0, 8'd60);
        rd(`ADDR_STATUS);
        check("edit", rdv, 16'h007F);
        check("active", {9'h000, o_station_addr}, 16'h007E);
        repeat (2) press(2'h1, 8'd20);
        press(2'h2, 8'd20);
        check("active", {9'h000, o_station_addr}, 16'h007D);
        check("hex", {8'h00, o_addr_hex}, 16'h007D);
        check("bcd", {4'h0, o_addr_bcd}, 16'h0125);
        scan(4'hD, 4'h1);
        wr(`ADDR_STATION, 16'h017D);
        scan(4'h7, 4'h8);
        $display("test address done");
        wr(`ADDR_FUNC_SEL, {12'h000, `FN_ADDR_DIRECT});
        press(2'h1, 8'd120);
        rd(`ADDR_STATUS);
        check("repeat", {15'h0000, rdv < 16'h0064}, 16'h0001);
        wr(`ADDR_FUNC_SEL, {12'h000, `FN_FB_HI});
        repeat (2) @(negedge i_ref_clk);
        check("fb high", o_fb_drive, `DEF_FB_HI);
        wr(`ADDR_FUNC_SEL, {12'h000, `FN_FB_LO});
        repeat (2) @(negedge i_ref_clk);
        check("fb low", o_fb_drive, `DEF_FB_LO);
        press(2'h0, 8'd20);
        press(2'h2, 8'd20);
        rd(`ADDR_FB_TRIM_LO);
        check("trim", {15'h0000, rdv > `DEF_FB_LO}, 16'h0001);
        $display("test feedback done");
        @(posedge i_ref_clk) i_nv_first_boot <= 1'b1;
        do_reset;
        press(2'h0, 8'd20);
        check("setup lang", {14'h0000, o_language}, 16'h0001);
        press(2'h1, 8'd20);
        check("setup lang", {14'h0000, o_language}, 16'h0000);
        $display("test first boot done");
        finish_test;
    end
    initial
    begin
        repeat (20000) @(posedge i_ref_clk);
        n_errors++;
        $display("BAD watchdog expected done seen timeout");
        finish_test;
    end
endmodule
